// ==== seg_pkg.sv ====
package seg_pkg;

  // ----------------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------------
  localparam int MEM_DEPTH = 32;
  localparam int ADDR_W = 5;
  localparam int NIB_W = 4;
  localparam int MAX_NIBS = 4;

  // ----------------------------------------------------------------------
  // Time-division modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STATIC,
    MODE_DIV2,
    MODE_DIV3,
    MODE_DIV4
  } mode_t;

  // ----------------------------------------------------------------------
  // Nibble counts, pointer steps and write masks per placement
  // ----------------------------------------------------------------------
  localparam logic [2:0] CNT_STATIC = 3'h4;
  localparam logic [2:0] CNT_DIV2 = 3'h4;
  localparam logic [2:0] CNT_DIV3 = 3'h3;
  localparam logic [2:0] CNT_DIV4 = 3'h2;
  localparam logic [2:0] CNT_SEG14 = 3'h4;
  localparam logic [3:0] MASK_STATIC = 4'h1;
  localparam logic [3:0] MASK_DIV2 = 4'h3;
  localparam logic [3:0] MASK_DIV3 = 4'h7;
  localparam logic [3:0] MASK_DIV4 = 4'hf;
  localparam logic [3:0] BIT_TWO_CLR = 4'hb;
  localparam int SEL_BIT = 7;
  localparam logic [ADDR_W-1:0] PTR_RST = 5'h00;
  localparam logic [NIB_W-1:0] MEM_RST = 4'h0;

endpackage

// ==== seg_char_decoder.sv ====
`timescale 1ns/1ps

// Combinational segment decoder. Nibbles are packed {N+3,N+2,N+1,N}.
module seg_char_decoder (
  input wire logic [7:0] code,
  output logic [15:0] div3_nibs,
  output logic [15:0] div4_nibs,
  output logic [15:0] seg14_nibs
);

  // ----------------------------------------------------------------------
  // Seven-segment tables, low four code bits only; code f blanks.
  // ----------------------------------------------------------------------
  always_comb begin
    case (code[3:0])
      4'h0: div3_nibs = 16'h0353;
      4'h1: div3_nibs = 16'h0003;
      4'h2: div3_nibs = 16'h0271;
      4'h3: div3_nibs = 16'h0073;
      4'h4: div3_nibs = 16'h0123;
      4'h5: div3_nibs = 16'h0172;
      4'h6: div3_nibs = 16'h0372;
      4'h7: div3_nibs = 16'h0013;
      4'h8: div3_nibs = 16'h0373;
      4'h9: div3_nibs = 16'h0173;
      4'ha: div3_nibs = 16'h0020;
      4'hb: div3_nibs = 16'h0370;
      4'hc: div3_nibs = 16'h0350;
      4'hd: div3_nibs = 16'h0060;
      4'he: div3_nibs = 16'h0262;
      default: div3_nibs = 16'h0000;
    endcase
  end

  always_comb begin
    case (code[3:0])
      4'h0: div4_nibs = 16'h00d7;
      4'h1: div4_nibs = 16'h0006;
      4'h2: div4_nibs = 16'h00e3;
      4'h3: div4_nibs = 16'h00a7;
      4'h4: div4_nibs = 16'h0036;
      4'h5: div4_nibs = 16'h00b5;
      4'h6: div4_nibs = 16'h00f5;
      4'h7: div4_nibs = 16'h0007;
      4'h8: div4_nibs = 16'h00f7;
      4'h9: div4_nibs = 16'h00b7;
      4'ha: div4_nibs = 16'h0020;
      4'hb: div4_nibs = 16'h00f1;
      4'hc: div4_nibs = 16'h00d1;
      4'hd: div4_nibs = 16'h00a0;
      4'he: div4_nibs = 16'h00e4;
      default: div4_nibs = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Fourteen-segment character ROM; unlisted codes show a blank cell.
  // ----------------------------------------------------------------------
  always_comb begin
    case (code)
      8'ha8: seg14_nibs = 16'h000a;
      8'ha9: seg14_nibs = 16'h5000;
      8'haa: seg14_nibs = 16'hf00f;
      8'hab: seg14_nibs = 16'ha005;
      8'haf: seg14_nibs = 16'h4002;
      8'hb0: seg14_nibs = 16'h47e2;
      8'hb6: seg14_nibs = 16'h25e4;
      8'hb7: seg14_nibs = 16'h0700;
      8'hb8: seg14_nibs = 16'h27e4;
      8'hc0: seg14_nibs = 16'ha7c0;
      8'hc1: seg14_nibs = 16'h2764;
      8'hc2: seg14_nibs = 16'h8785;
      8'hc3: seg14_nibs = 16'h01e0;
      8'hc4: seg14_nibs = 16'h8781;
      8'hc5: seg14_nibs = 16'h21e4;
      8'hc6: seg14_nibs = 16'h2164;
      8'hc7: seg14_nibs = 16'h05e4;
      8'hc9: seg14_nibs = 16'h8181;
      8'hca: seg14_nibs = 16'h06c0;
      8'hcb: seg14_nibs = 16'h206a;
      8'hcc: seg14_nibs = 16'h00e0;
      8'hcf: seg14_nibs = 16'h07e0;
      8'hd1: seg14_nibs = 16'h07e8;
      8'hd2: seg14_nibs = 16'h236c;
      8'hd4: seg14_nibs = 16'h8101;
      8'hd5: seg14_nibs = 16'h06e0;
      8'hd8: seg14_nibs = 16'h500a;
      8'hd9: seg14_nibs = 16'h9002;
      default: seg14_nibs = 16'h0000;
    endcase
  end

endmodule

// ==== seg_mem_writer.sv ====
`timescale 1ns/1ps

// Functional notes
// - Display memory is 32 entries of 4 bits, written by bytes or commands.
// - With decoding on, four-way writes decoder output and three-way writes it for bit 7 low, dropping bit-7-high bytes; otherwise the raw byte.
// - Raw bytes scatter over two to four consecutive addresses by mode.
// - Decoded placement depends on three/four-way mode and byte bit 7.
// - Commands may rewrite a whole entry or a single bit.
// - Seven-segment decoder uses low nibble; codes 0a-0f are symbols, 0f blank.
// - Three-way seven-segment writes three nibbles at N, N+1, N+2.
// - Four-way seven-segment writes two nibbles at N and N+1.
// - Fourteen-segment decoder treats the byte as an 8-bit character code.
// - Fourteen-segment only in four-way mode, four nibbles N to N+3.
// - Static mode puts low four bits in bit 0 of four addresses.
// - Static mode uses only bit 0; pointer advances by four.
// - Two-way mode puts even bits in bit 0, odd bits in bit 1.
// - Two-way mode uses bits 0 and 1; pointer advances by four.
// - Three-way spreads eight bits over bits 0-2; third bit_two forced 0.
// - Three-way with decoding also forces bit_two of the first address 0.
// - Three-way uses bits 0 to 2; pointer advances by three.
// - Bit 7 low picks seven-segment decoder, high picks fourteen-segment.
// - Five-bit pointer wraps from 31 to 0.
module seg_mem_writer (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [1:0] mode,
  input wire logic decode_en,
  input wire logic byte_valid,
  input wire logic cmd_sel,
  input wire logic [7:0] byte_in,
  input wire logic ptr_load,
  input wire logic [4:0] ptr_value,
  input wire logic cmd_nib_we,
  input wire logic [3:0] cmd_nib,
  input wire logic cmd_bit_we,
  input wire logic [1:0] cmd_bit_sel,
  input wire logic cmd_bit_val,
  input wire logic [4:0] rd_addr,
  output logic [3:0] rd_data_r,
  output logic [4:0] ptr_r,
  output logic byte_done_r
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Pointer arithmetic keeps five bits so the count wraps past 31.
  function automatic logic [4:0] addr_add(input logic [4:0] base,
                                          input logic [2:0] step);
    logic [5:0] sum;
    sum = {1'b0, base} + {3'b000, step};
    return sum[4:0];
  endfunction

  // Merge new bits into an entry under a mask, keeping the others.
  function automatic logic [3:0] merge(input logic [3:0] old_v,
                                       input logic [3:0] new_v,
                                       input logic [3:0] msk);
    return (old_v & ~msk) | (new_v & msk);
  endfunction

  // ----------------------------------------------------------------------
  // Storage and decoder
  // ----------------------------------------------------------------------
  logic [3:0] mem_r [seg_pkg::MEM_DEPTH];
  logic [15:0] div3_nibs;
  logic [15:0] div4_nibs;
  logic [15:0] seg14_nibs;

  seg_char_decoder u_dec (
    .code(byte_in),
    .div3_nibs(div3_nibs),
    .div4_nibs(div4_nibs),
    .seg14_nibs(seg14_nibs)
  );

  // ----------------------------------------------------------------------
  // Placement selection
  // ----------------------------------------------------------------------
  seg_pkg::mode_t mode_sel;
  wire data_strobe = byte_valid & ~cmd_sel;
  wire use_seg14 = byte_in[seg_pkg::SEL_BIT];
  wire [15:0] raw_static;
  wire [15:0] raw_div2;
  wire [15:0] raw_div3;
  wire [15:0] raw_div4;
  wire [15:0] dec_div3;
  logic [15:0] place_nibs;
  logic [3:0] place_mask;
  logic [2:0] place_cnt;
  logic place_ok;

  assign mode_sel = seg_pkg::mode_t'(mode);

  // Raw layouts, lowest byte bits land at the pointer address.
  assign raw_static = {3'b000, byte_in[3], 3'b000, byte_in[2],
                       3'b000, byte_in[1], 3'b000, byte_in[0]};
  assign raw_div2 = {2'b00, byte_in[7], byte_in[6],
                     2'b00, byte_in[5], byte_in[4],
                     2'b00, byte_in[3], byte_in[2],
                     2'b00, byte_in[1], byte_in[0]};
  assign raw_div3 = {4'h0, 2'b00, byte_in[7:6], 1'b0, byte_in[5:3],
                     1'b0, byte_in[2:0]};
  assign raw_div4 = {8'h00, byte_in};

  // Decoded three-way pattern with bit_two cleared at N and N+2.
  assign dec_div3 = {4'h0, div3_nibs[11:8] & seg_pkg::BIT_TWO_CLR,
                     div3_nibs[7:4],
                     div3_nibs[3:0] & seg_pkg::BIT_TWO_CLR};

  // Choose nibbles, mask and count from mode, decode enable and bit 7.
  // A fourteen-segment code in three-way mode has no valid layout,
  // so the byte is dropped rather than written as garbage.
  always_comb begin
    place_nibs = raw_div4;
    place_mask = seg_pkg::MASK_DIV4;
    place_cnt = seg_pkg::CNT_DIV4;
    place_ok = 1'b1;
    case (mode_sel)
      seg_pkg::MODE_STATIC: begin
        place_nibs = raw_static;
        place_mask = seg_pkg::MASK_STATIC;
        place_cnt = seg_pkg::CNT_STATIC;
      end
      seg_pkg::MODE_DIV2: begin
        place_nibs = raw_div2;
        place_mask = seg_pkg::MASK_DIV2;
        place_cnt = seg_pkg::CNT_DIV2;
      end
      seg_pkg::MODE_DIV3: begin
        place_mask = seg_pkg::MASK_DIV3;
        place_cnt = seg_pkg::CNT_DIV3;
        if (!decode_en) begin
          place_nibs = raw_div3;
        end else if (!use_seg14) begin
          place_nibs = dec_div3;
        end else begin
          place_nibs = raw_div3;
          place_ok = 1'b0;
        end
      end
      seg_pkg::MODE_DIV4: begin
        if (!decode_en) begin
          place_nibs = raw_div4;
        end else if (!use_seg14) begin
          place_nibs = div4_nibs;
        end else begin
          place_nibs = seg14_nibs;
          place_cnt = seg_pkg::CNT_SEG14;
        end
      end
      default: begin
        place_ok = 1'b0;
      end
    endcase
  end

  wire byte_write = data_strobe & place_ok;

  // Command edits act on the entry at the pointer.
  wire [3:0] bit_mask = 4'h1 << cmd_bit_sel;
  wire [3:0] bit_data = {4{cmd_bit_val}};
  wire cmd_write = ~data_strobe & (cmd_nib_we | cmd_bit_we);
  wire [3:0] cmd_mask = cmd_nib_we ? seg_pkg::MASK_DIV4 : bit_mask;
  wire [3:0] cmd_data = cmd_nib_we ? cmd_nib : bit_data;

  // ----------------------------------------------------------------------
  // Memory update
  // ----------------------------------------------------------------------

  // One byte writes all of its entries in a single cycle, so the feeder
  // never has to wait; a data byte wins over a same-cycle command edit.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int k = 0; k < seg_pkg::MEM_DEPTH; k++) begin
        mem_r[k] <= seg_pkg::MEM_RST;
      end
    end else if (clk_en) begin
      if (byte_write) begin
        for (int i = 0; i < seg_pkg::MAX_NIBS; i++) begin
          if (i < int'(place_cnt)) begin
            mem_r[addr_add(ptr_r, 3'(i))] <=
              merge(mem_r[addr_add(ptr_r, 3'(i))],
                    place_nibs[i*4 +: 4], place_mask);
          end
        end
      end else if (cmd_write) begin
        mem_r[ptr_r] <= merge(mem_r[ptr_r], cmd_data, cmd_mask);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pointer, done pulse and read port
  // ----------------------------------------------------------------------

  // A load takes priority over the advance of a same-cycle byte.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ptr_r <= seg_pkg::PTR_RST;
      byte_done_r <= 1'b0;
    end else if (clk_en) begin
      byte_done_r <= byte_write;
      if (ptr_load) begin
        ptr_r <= ptr_value;
      end else if (byte_write) begin
        ptr_r <= addr_add(ptr_r, place_cnt);
      end
    end
  end

  // Registered read so the output comes from a flop.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_data_r <= seg_pkg::MEM_RST;
    end else if (clk_en) begin
      rd_data_r <= mem_r[rd_addr];
    end
  end

endmodule

// ==== seg_mem_writer_sva.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checker for the display memory writer
// ------------------------------------------------------------
module seg_mem_writer_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [1:0] mode,
  input wire logic decode_en,
  input wire logic byte_valid,
  input wire logic cmd_sel,
  input wire logic [7:0] byte_in,
  input wire logic ptr_load,
  input wire logic [4:0] ptr_value,
  input wire logic cmd_nib_we,
  input wire logic [3:0] cmd_nib,
  input wire logic cmd_bit_we,
  input wire logic [1:0] cmd_bit_sel,
  input wire logic cmd_bit_val,
  input wire logic [4:0] rd_addr,
  input wire logic [3:0] rd_data_r,
  input wire logic [4:0] ptr_r,
  input wire logic byte_done_r
);
  // A fourteen-segment code in three-way mode has no layout, so it drops.
  wire logic drop = mode == 2'h2 && decode_en && byte_in[7];
  wire logic take = clk_en && byte_valid && !cmd_sel && !drop;
  wire logic quiet = clk_en && !byte_valid && !cmd_nib_we && !cmd_bit_we;
  wire logic wide = decode_en && byte_in[7];
  wire logic [4:0] step = !mode[1] ? 5'h04 : !mode[0] ? 5'h03 :
    wide ? 5'h04 : 5'h02;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  done_after_take_a: assert property (take |=> byte_done_r)
    else $error("byte_done_r missing after a byte");
  done_only_take_a: assert property (clk_en && !take |=> !byte_done_r)
    else $error("byte_done_r without a byte");
  ptr_step_a: assert property (take && !ptr_load
    |=> ptr_r == 5'($past(ptr_r) + $past(step)))
    else $error("pointer step wrong");
  ptr_load_a: assert property (clk_en && ptr_load
    |=> ptr_r == $past(ptr_value)) else $error("pointer load lost");
  ptr_hold_a: assert property (clk_en && !ptr_load && !take
    |=> $stable(ptr_r)) else $error("pointer moved without a byte");
  freeze_a: assert property (!clk_en
    |=> $stable(ptr_r) && $stable(rd_data_r) && $stable(byte_done_r))
    else $error("state moved with clock enable low");
  nib_write_a: assert property (
    clk_en && cmd_nib_we && !(byte_valid && !cmd_sel)
    ##1 quiet && rd_addr == $past(ptr_r) |=> rd_data_r == $past(cmd_nib, 2))
    else $error("nibble command not stored");
  bit_write_a: assert property (
    clk_en && cmd_bit_we && !cmd_nib_we && !(byte_valid && !cmd_sel)
    ##1 quiet && rd_addr == $past(ptr_r)
    |=> rd_data_r[$past(cmd_bit_sel, 2)] == $past(cmd_bit_val, 2))
    else $error("bit command not stored");
endmodule

// ==== seg_byte_feeder.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Command/data register model feeding received bytes
// ------------------------------------------------------------
module seg_byte_feeder (
  input wire logic mclk,
  input wire logic go,
  input wire logic is_cmd,
  input wire logic [7:0] value,
  output logic byte_valid,
  output logic cmd_sel,
  output logic [7:0] byte_in
);
  initial begin
    byte_valid = 1'b0;
    cmd_sel = 1'b1;
    byte_in = 8'h00;
  end

  // Idle cycles show inverted leftovers, so a stale byte never looks good.
  always @(posedge mclk) begin
    byte_valid <= #1 go;
    cmd_sel <= #1 go ? is_cmd : ~cmd_sel;
    byte_in <= #1 go ? value : ~byte_in;
  end
endmodule

// ==== segment_decode_display_memory_writer_test.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module segment_decode_display_memory_writer_test;
  logic mclk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, decode_en = 1'b0;
  logic go = 1'b0, is_cmd = 1'b0, ptr_load = 1'b0, cmd_nib_we = 1'b0;
  logic cmd_bit_we = 1'b0, cmd_bit_val = 1'b0, byte_valid, cmd_sel;
  logic [1:0] mode = 2'h0, cmd_bit_sel = 2'h0;
  logic [7:0] value = 8'h00, byte_in;
  logic [4:0] ptr_value = 5'h00, rd_addr = 5'h00, ptr_r;
  logic [3:0] cmd_nib = 4'h0, rd_data_r;
  logic byte_done_r;
  int n_mismatch = 0, checked = 0;

  seg_byte_feeder u_seg_byte_feeder (.mclk(mclk), .go(go), .is_cmd(is_cmd),
    .value(value), .byte_valid(byte_valid), .cmd_sel(cmd_sel),
    .byte_in(byte_in));
  seg_mem_writer u_seg_mem_writer (.mclk(mclk), .rst_b(rst_b),
    .clk_en(clk_en), .mode(mode), .decode_en(decode_en),
    .byte_valid(byte_valid), .cmd_sel(cmd_sel), .byte_in(byte_in),
    .ptr_load(ptr_load), .ptr_value(ptr_value), .cmd_nib_we(cmd_nib_we),
    .cmd_nib(cmd_nib), .cmd_bit_we(cmd_bit_we), .cmd_bit_sel(cmd_bit_sel),
    .cmd_bit_val(cmd_bit_val), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
    .ptr_r(ptr_r), .byte_done_r(byte_done_r));

  // Clock at 200 MHz.
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Bytes reach the design one cycle after push, back to back if repeated.
  task automatic push(input logic [7:0] v, input logic c);
    value = v;
    is_cmd = c;
    go = 1'b1;
    @(posedge mclk) #1;
  endtask

  task automatic flush;
    go = 1'b0;
    repeat (2) @(posedge mclk) #1;
  endtask

  task automatic setp(input logic [4:0] p);
    ptr_value = p;
    ptr_load = 1'b1;
    @(posedge mclk) #1 ptr_load = 1'b0;
  endtask

  task automatic peek(input logic [4:0] a, input logic [3:0] e);
    rd_addr = a;
    @(posedge mclk) #1;
    chk("mem", {4'h0, e}, {4'h0, rd_data_r});
  endtask

  task automatic t_div3;
    logic [11:0] t [16] = '{12'h353, 12'h003, 12'h271, 12'h073, 12'h123,
      12'h172, 12'h372, 12'h013, 12'h373, 12'h173, 12'h020, 12'h370,
      12'h350, 12'h060, 12'h262, 12'h000};
    mode = 2'h2;
    decode_en = 1'b1;
    for (int i = 0; i < 16; i++) begin
      setp(5'h00);
      push({4'h0, i[3:0]}, 1'b0);
      flush;
      for (int k = 0; k < 3; k++) peek(k[4:0], t[i][4*k +: 4]);
    end
    push(8'hc0, 1'b0);
    flush;
    chk("ptr", 8'h03, {3'h0, ptr_r});
    peek(5'h03, 4'h0);
    decode_en = 1'b0;
    push(8'hff, 1'b0);
    flush;
    peek(5'h03, 4'h7);
    peek(5'h05, 4'h3);
  endtask

  task automatic t_div4;
    logic [7:0] t [16] = '{8'hd7, 8'h06, 8'he3, 8'ha7, 8'h36, 8'hb5, 8'hf5,
      8'h07, 8'hf7, 8'hb7, 8'h20, 8'hf1, 8'hd1, 8'ha0, 8'he4, 8'h00};
    mode = 2'h3;
    decode_en = 1'b1;
    setp(5'h00);
    for (int i = 0; i < 16; i++) push({4'h0, i[3:0]}, 1'b0);
    flush;
    chk("ptr", 8'h00, {3'h0, ptr_r});
    for (int i = 0; i < 16; i++) begin
      peek(5'(2 * i), t[i][3:0]);
      peek(5'(2 * i + 1), t[i][7:4]);
    end
    setp(5'h1e);
    push(8'hc0, 1'b0);
    push(8'hd1, 1'b0);
    flush;
    // The decoder switch must wait until the last coded byte has landed.
    decode_en = 1'b0;
    push(8'h5a, 1'b0);
    flush;
    chk("ptr", 8'h08, {3'h0, ptr_r});
    for (int i = 0; i < 10; i++)
      peek(5'(30 + i), 4'(40'h5a07e8a7c0 >> (4 * i)));
  endtask

  task automatic t_static_div2;
    mode = 2'h0;
    decode_en = 1'b1;
    setp(5'h1e);
    cmd_nib = 4'he;
    cmd_nib_we = 1'b1;
    @(posedge mclk) #1 cmd_nib_we = 1'b0;
    push(8'ha5, 1'b0);
    push(8'hff, 1'b1);
    flush;
    chk("ptr", 8'h02, {3'h0, ptr_r});
    for (int i = 0; i < 4; i++)
      peek(5'(30 + i), 4'(16'ha7cf >> (4 * i)));
    mode = 2'h1;
    setp(5'h04);
    push(8'hc9, 1'b0);
    flush;
    chk("ptr", 8'h08, {3'h0, ptr_r});
    for (int i = 0; i < 4; i++)
      peek(5'(4 + i), 4'(16'h7825 >> (4 * i)));
  endtask

  task automatic t_cmd;
    setp(5'h09);
    rd_addr = 5'h09;
    cmd_nib = 4'h9;
    cmd_nib_we = 1'b1;
    @(posedge mclk) #1 cmd_nib_we = 1'b0;
    cmd_bit_sel = 2'h2;
    cmd_bit_val = 1'b1;
    cmd_bit_we = 1'b1;
    @(posedge mclk) #1 cmd_bit_we = 1'b0;
    @(posedge mclk) #1 clk_en = 1'b0;
    cmd_bit_sel = 2'h0;
    cmd_bit_val = 1'b0;
    cmd_bit_we = 1'b1;
    @(posedge mclk) #1 clk_en = 1'b1;
    cmd_bit_we = 1'b0;
    peek(5'h09, 4'hd);
    chk("ptr", 8'h09, {3'h0, ptr_r});
  endtask

  // Main sequence; the design runs a few hundred cycles at most.
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst_b = 1'b1;
    chk("ptr", 8'h00, {3'h0, ptr_r});
    peek(5'h1f, 4'h0);
    t_div3();
    t_div4();
    t_static_div2();
    t_cmd();
    wrap_up();
  end

  // Watchdog cuts a hang short well past the expected run length.
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule

bind seg_mem_writer seg_mem_writer_chk u_seg_mem_writer_chk (.mclk(mclk),
  .rst_b(rst_b), .clk_en(clk_en), .mode(mode), .decode_en(decode_en),
  .byte_valid(byte_valid), .cmd_sel(cmd_sel), .byte_in(byte_in),
  .ptr_load(ptr_load), .ptr_value(ptr_value), .cmd_nib_we(cmd_nib_we),
  .cmd_nib(cmd_nib), .cmd_bit_we(cmd_bit_we), .cmd_bit_sel(cmd_bit_sel),
  .cmd_bit_val(cmd_bit_val), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
  .ptr_r(ptr_r), .byte_done_r(byte_done_r));
